/* core/gdp_pkg.sv */
package gdp_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned WAKE_PULSE_US   = 56;
  localparam int unsigned WAKE_PULSE_CYC  = WAKE_PULSE_US * CLK_MHZ;
  localparam int unsigned RETRY_DELAY_US  = 1000;
  localparam int unsigned RETRY_DELAY_CYC = RETRY_DELAY_US * CLK_MHZ;
  localparam int unsigned PUMP_FILTER_US  = 10;
  localparam int unsigned PUMP_FILTER_CYC = PUMP_FILTER_US * CLK_MHZ;
  localparam int unsigned DS_FILTER_NS    = 1000;
  localparam int unsigned DS_FILTER_CYC   = (DS_FILTER_NS * CLK_MHZ) / 1000;
  localparam int unsigned DEAD_STEP_NS    = 50;
  localparam int unsigned DEAD_STEP_CYC   =
    (DEAD_STEP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_FLAGS  = 4'h4;
  localparam logic [3:0] REG_LIVE   = 4'h8;
  localparam int unsigned CTRL_W    = 15;
  localparam int unsigned GOSTBY_POS = 15;
  localparam logic [14:0] CTRL_RESET = 15'h0000;
  localparam logic [13:0] FLAGS_RESET = 14'h0001;
  localparam int unsigned LIVE_IGN_POS   = 0;
  localparam int unsigned LIVE_PUMP_NOT_READY_FLAG_POS  = 1;
  localparam int unsigned LIVE_RETRY_POS = 2;
  localparam int unsigned LIVE_MODE_POS  = 5;
  localparam int unsigned LIVE_MON_POS   = 7;
  localparam int unsigned LIVE_GSB_POS   = 13;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       go_unused;         // Bit 14 reads as zero.
    logic [3:0] dead_time_setting;
    logic [1:0] short_detect_threshold;
    logic [2:0] phase_sink_test_select;
    logic       offstate_monitor_enable;
    logic       short_shutdown_inhibit;
    logic       fast_sink_timing_select;
    logic       pump_off_bit;
    logic       thermal_mode_select;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] lower_switch_short_flag;
    logic [2:0] upper_switch_short_flag;
    logic [2:0] shoot_through_flag;
    logic       pump_low_flag;
    logic       thermal_shutdown_second;
    logic       thermal_shutdown_first_or_warning_second;
    logic       thermal_warning_first;
    logic       disable_flag;
  } flags_type;

  typedef struct packed {
    logic       driver_off_pin;
    logic       ignition_wake_input;
    logic [2:0] high_side_input_n;
    logic [2:0] low_side_input;
    logic       temp_warn_first;
    logic       temp_shut_first;
    logic       temp_shut_second;
    logic       pump_below_low;
    logic       pump_ready;
    logic [2:0] upper_ds_over;
    logic [2:0] lower_ds_over;
  } pins_type;

  typedef struct packed {
    logic [2:0] high_gate_out;
    logic [2:0] low_gate_out;
    logic [2:0] fast_sink_high;
    logic [2:0] fast_sink_low;
  } gates_type;

  typedef enum logic [1:0] {
    MODE_ACTIVE, MODE_REG_STANDBY, MODE_RETRY, MODE_BAT_STANDBY
  } mode_type;

endpackage : gdp_pkg

/* core/gate_driver_protection_control.sv */
// How it works
// - Driver-off pin low enables all gate drivers, high disables them.
// - Pin high latches disable flag; pin low and read-clear restore.
// - Ignition input high wakes the device; its live level is readable.
// - Normal mode: first warning threshold latches first warning flag.
// - Normal mode first shutdown: drivers, pump off, combined flag latched.
// - Normal mode second shutdown also stops regulator, latches its flag.
// - Each regulator stop counts up; delay restarts it; seven means standby.
// - Warning mode: second threshold only latches combined flag as warning.
// - Warning mode second shutdown: drivers, pump, regulator off, flag set.
// - Read-clear drops a thermal flag only below its threshold.
// - Wake from regulator standby: active, interrupt low about 56 us.
// - Pump off in standby, after thermal shutdown, or when pump-off bit set.
// - Pump low beyond filter time stops drivers, latches pump-low flag.
// - Not-ready flag holds until pump reports ready after startup.
// - Per-bridge control: high input active low, low input active high.
// - Minimum dead time inserted only when host dead time is shorter.
// - Both inputs of a bridge active turns both its gates off.
// - Both active beyond dead time: shoot-through flag, bridge disabled.
// - Fast sink one dead time after off, or when complement goes high.
// - Drain-source excess while sourcing latches short flag, may shut down.
// - Phase test bit selects sink test current instead of source current.
// - Off-state monitor: live unlatched results, no functional error bit.
// - Latched flags are mirrored into the global status byte categories.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_protection_control
  import gdp_pkg::*;
#(
  parameter int unsigned WAKE_CYC  = WAKE_PULSE_CYC,
  parameter int unsigned RETRY_CYC = RETRY_DELAY_CYC
) (
  input  wire logic        CLK_I,              // 200 MHz clock.
  input  wire logic        RESET_N_I,          // Synchronous reset, low.
  input  wire logic        CE_I,               // Clock enable, freezes state.
  input  wire pins_type    PINS_I,             // Asynchronous pins, comparators.
  input  wire logic [3:0]  AVS_ADDRESS_I,      // Byte address.
  input  wire logic        AVS_READ_I,         // Read request.
  input  wire logic        AVS_WRITE_I,        // Write request.
  input  wire logic [3:0]  AVS_BYTEENABLE_I,   // Byte lanes.
  input  wire logic [31:0] AVS_WRITEDATA_I,    // Write data.
  output logic [31:0]      AVS_READDATA_O,     // Read data.
  output logic             AVS_WAITREQUEST_O,  // Stall.
  output gates_type        GATES_O,            // Gate and fast sink drives.
  output logic             PUMP_ENABLE_O,      // Charge pump on.
  output logic             REGULATOR_ENABLE_O, // Supply regulator on.
  output logic [2:0]       SINK_TEST_O,        // Phase node sink test select.
  output logic [1:0]       SHORT_THRESHOLD_O,  // Short threshold step.
  output logic             INTERRUPT_OUT_N_O,  // Wake pulse, active low.
  output logic [7:0]       GLOBAL_STATUS_O     // Category summary byte.
);

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  pins_type pins_meta_q;
  pins_type s;

  // Stage one feeds only stage two so metastability never fans out.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      // Reset to the pull levels so no false input edge follows reset.
      pins_meta_q                   <= '0;
      s                             <= '0;
      pins_meta_q.driver_off_pin    <= 1'b1;
      pins_meta_q.high_side_input_n <= 3'h7;
      s.driver_off_pin              <= 1'b1;
      s.high_side_input_n           <= 3'h7;
    end else if (CE_I) begin
      pins_meta_q <= PINS_I;
      s           <= pins_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------
  ctrl_type    ctrl_q;
  flags_type   flags_q;
  mode_type    mode_q;
  logic        ack_q;
  logic        req;
  logic        rd_clear;
  logic        go_standby;
  logic [15:0] ctrl_merged;
  logic [31:0] live;
  logic [7:0]  gsb_q;
  logic [2:0]  retry_q;
  logic        pump_not_ready_flag_q;
  logic [5:0]  mon_live;

  // Every access waits exactly one cycle, then completes.
  assign req               = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~ack_q;
  assign rd_clear = ack_q & AVS_READ_I & (AVS_ADDRESS_I == REG_FLAGS);

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
    end else if (CE_I) begin
      ack_q <= req & ~ack_q;
    end
  end

  // Live view: readable state of the block itself.
  always_comb begin
    live                                  = '0;
    live[LIVE_IGN_POS]                    = s.ignition_wake_input;
    live[LIVE_PUMP_NOT_READY_FLAG_POS]                   = pump_not_ready_flag_q;
    live[LIVE_RETRY_POS +: 3]             = retry_q;
    live[LIVE_MODE_POS +: 2]              = mode_q;
    live[LIVE_MON_POS +: 6]               = mon_live;
    live[LIVE_GSB_POS +: 8]               = gsb_q;
  end

  // Read data is captured while waitrequest is high and stands at ack.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      AVS_READDATA_O <= '0;
    end else if (CE_I && AVS_READ_I && !ack_q) begin
      unique case (AVS_ADDRESS_I)
        REG_CTRL:  AVS_READDATA_O <= {17'h0, ctrl_q};
        REG_FLAGS: AVS_READDATA_O <= {18'h0, flags_q};
        REG_LIVE:  AVS_READDATA_O <= live;
        default:   AVS_READDATA_O <= '0;
      endcase
    end
  end

  // Byte-lane merge; the standby request bit is a one-shot, never stored.
  always_comb begin
    ctrl_merged = {1'b0, ctrl_q};
    if (AVS_BYTEENABLE_I[0]) begin
      ctrl_merged[7:0] = AVS_WRITEDATA_I[7:0];
    end
    if (AVS_BYTEENABLE_I[1]) begin
      ctrl_merged[15:8] = AVS_WRITEDATA_I[15:8];
    end
  end

  assign go_standby = ack_q & AVS_WRITE_I & (AVS_ADDRESS_I == REG_CTRL) &
                      ctrl_merged[GOSTBY_POS];

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= ctrl_type'(CTRL_RESET);
    end else if (CE_I && ack_q && AVS_WRITE_I &&
                 AVS_ADDRESS_I == REG_CTRL) begin
      ctrl_q <= ctrl_type'({1'b0, ctrl_merged[13:0]});
    end
  end

  assign SINK_TEST_O       = ctrl_q.phase_sink_test_select;
  assign SHORT_THRESHOLD_O = ctrl_q.short_detect_threshold;

  // ----------------------------------------------------------------------
  // Operating mode, regulator retry and wake pulse
  // ----------------------------------------------------------------------
  logic [31:0] retry_cnt_q;
  logic [31:0] int_cnt_q;
  logic        int_act_q;
  logic        wake_reg;

  assign wake_reg = (mode_q == MODE_REG_STANDBY) & s.ignition_wake_input;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      mode_q      <= MODE_ACTIVE;
      retry_q     <= 3'h0;
      retry_cnt_q <= '0;
    end else if (CE_I) begin
      unique case (mode_q)
        MODE_ACTIVE: begin
          if (s.temp_shut_second) begin
            retry_q     <= retry_q + 3'h1;
            retry_cnt_q <= RETRY_CYC - 1;
            mode_q      <= (retry_q == 3'h6) ? MODE_BAT_STANDBY : MODE_RETRY;
          end else if (go_standby) begin
            mode_q <= MODE_REG_STANDBY;
          end
        end
        MODE_RETRY: begin
          if (retry_cnt_q == 0) begin
            mode_q <= MODE_ACTIVE;
          end else begin
            retry_cnt_q <= retry_cnt_q - 1;
          end
        end
        MODE_REG_STANDBY: begin
          if (wake_reg) begin
            mode_q <= MODE_ACTIVE;
          end
        end
        MODE_BAT_STANDBY: begin
          if (s.ignition_wake_input) begin
            mode_q  <= MODE_ACTIVE;
            retry_q <= 3'h0;
          end
        end
      endcase
    end
  end

  // The regulator goes dark only for the retry delay or battery standby.
  assign REGULATOR_ENABLE_O = (mode_q == MODE_ACTIVE) ||
                              (mode_q == MODE_REG_STANDBY);

  // Wake pulse lasts exactly WAKE_CYC cycles.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      int_cnt_q <= '0;
      int_act_q <= 1'b0;
    end else if (CE_I) begin
      if (wake_reg) begin
        int_cnt_q <= WAKE_CYC - 1;
        int_act_q <= 1'b1;
      end else if (int_cnt_q != 0) begin
        int_cnt_q <= int_cnt_q - 1;
      end else begin
        int_act_q <= 1'b0;
      end
    end
  end

  assign INTERRUPT_OUT_N_O = ~int_act_q;

  // ----------------------------------------------------------------------
  // Thermal, pump and driver enables
  // ----------------------------------------------------------------------
  logic        therm_sd;
  logic        drivers_on;
  logic        pump_en_q;
  logic [15:0] pump_cnt_q;
  logic        pump_low_cause;

  // Normal mode shuts down at the first threshold, warning mode at the
  // second only.
  assign therm_sd = ctrl_q.thermal_mode_select ?
                    flags_q.thermal_shutdown_second :
                    (flags_q.thermal_shutdown_first_or_warning_second |
                     flags_q.thermal_shutdown_second);

  assign drivers_on = (mode_q == MODE_ACTIVE) & ~s.driver_off_pin &
                      ~flags_q.disable_flag & ~therm_sd &
                      ~flags_q.pump_low_flag;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pump_en_q <= 1'b0;
      pump_not_ready_flag_q    <= 1'b1;
    end else if (CE_I) begin
      pump_en_q <= (mode_q == MODE_ACTIVE) & ~therm_sd &
                   ~ctrl_q.pump_off_bit;
      pump_not_ready_flag_q    <= ~pump_en_q | (pump_not_ready_flag_q & ~s.pump_ready);
    end
  end

  assign PUMP_ENABLE_O = pump_en_q;

  // Pump-low filter: a dip must persist for the full filter time.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pump_cnt_q <= '0;
    end else if (CE_I) begin
      if (!(pump_en_q && s.pump_below_low)) begin
        pump_cnt_q <= '0;
      end else if (!pump_low_cause) begin
        pump_cnt_q <= pump_cnt_q + 16'h0001;
      end
    end
  end

  assign pump_low_cause = (pump_cnt_q == 16'(PUMP_FILTER_CYC));

  // ----------------------------------------------------------------------
  // Half-bridge channels
  // ----------------------------------------------------------------------
  logic [7:0] dead_cyc;
  logic [2:0] st_cause;
  logic [2:0] hs_short_cause;
  logic [2:0] ls_short_cause;
  gates_type  gates;

  assign dead_cyc = 8'(({4'h0, ctrl_q.dead_time_setting} + 8'h01) *
                       DEAD_STEP_CYC);

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic       hi_q;
    logic       lo_q;
    logic       sink_hi_q;
    logic       sink_lo_q;
    logic [7:0] hi_off_q;
    logic [7:0] lo_off_q;
    logic [7:0] both_q;
    logic [7:0] dsh_q;
    logic [7:0] dsl_q;
    logic       hs_act;
    logic       ls_act;
    logic       phase_en;

    assign hs_act   = ~s.high_side_input_n[p];
    assign ls_act   = s.low_side_input[p];
    assign phase_en = drivers_on & ~flags_q.shoot_through_flag[p] &
                      ~(~ctrl_q.short_shutdown_inhibit &
                        (flags_q.upper_switch_short_flag[p] |
                         flags_q.lower_switch_short_flag[p]));

    // Gate turns on only once the other side has been off a dead time;
    // a longer host gap already satisfies the count, so adds nothing.
    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        hi_q <= 1'b0;
        lo_q <= 1'b0;
      end else if (CE_I) begin
        hi_q <= phase_en & hs_act & ~ls_act & ~lo_q &
                (lo_off_q >= dead_cyc);
        lo_q <= phase_en & ls_act & ~hs_act & ~hi_q &
                (hi_off_q >= dead_cyc);
      end
    end

    // Off-time counters start saturated so the first edge is not delayed.
    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        hi_off_q <= 8'hff;
        lo_off_q <= 8'hff;
      end else if (CE_I) begin
        hi_off_q <= hi_q ? 8'h00 : hi_off_q + {7'h0, hi_off_q != 8'hff};
        lo_off_q <= lo_q ? 8'h00 : lo_off_q + {7'h0, lo_off_q != 8'hff};
      end
    end

    // Fast sink after a dead time, or as soon as the complement is on.
    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        sink_hi_q <= 1'b1;
        sink_lo_q <= 1'b1;
      end else if (CE_I) begin
        sink_hi_q <= ~hi_q & (ctrl_q.fast_sink_timing_select ? lo_q :
                              (hi_off_q >= dead_cyc));
        sink_lo_q <= ~lo_q & (ctrl_q.fast_sink_timing_select ? hi_q :
                              (lo_off_q >= dead_cyc));
      end
    end

    // Both-active and drain-source filters saturate at their limits.
    always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
        both_q <= '0;
        dsh_q  <= '0;
        dsl_q  <= '0;
      end else if (CE_I) begin
        both_q <= (hs_act & ls_act) ?
                  both_q + {7'h0, both_q != 8'hff} : 8'h00;
        dsh_q  <= (hi_q & s.upper_ds_over[p]) ?
                  dsh_q + {7'h0, dsh_q != 8'(DS_FILTER_CYC)} : 8'h00;
        dsl_q  <= (lo_q & s.lower_ds_over[p]) ?
                  dsl_q + {7'h0, dsl_q != 8'(DS_FILTER_CYC)} : 8'h00;
      end
    end

    assign st_cause[p]       = hs_act & ls_act & (both_q >= dead_cyc);
    assign hs_short_cause[p] = (dsh_q == 8'(DS_FILTER_CYC));
    assign ls_short_cause[p] = (dsl_q == 8'(DS_FILTER_CYC));
    assign mon_live[p]       = ctrl_q.offstate_monitor_enable & ~hi_q &
                               s.upper_ds_over[p];
    assign mon_live[p + 3]   = ctrl_q.offstate_monitor_enable & ~lo_q &
                               s.lower_ds_over[p];
    assign gates.high_gate_out[p]  = hi_q;
    assign gates.low_gate_out[p]   = lo_q;
    assign gates.fast_sink_high[p] = sink_hi_q;
    assign gates.fast_sink_low[p]  = sink_lo_q;
  end

  assign GATES_O = gates;

  // ----------------------------------------------------------------------
  // Latched flags and status byte
  // ----------------------------------------------------------------------
  // A live cause re-sets its flag in the clear cycle, so set wins and a
  // flag only drops once its cause is gone.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      flags_q <= flags_type'(FLAGS_RESET);
    end else if (CE_I) begin
      flags_q.disable_flag <= s.driver_off_pin |
                              (flags_q.disable_flag & ~rd_clear);
      flags_q.thermal_warning_first <= s.temp_warn_first |
        (flags_q.thermal_warning_first & ~rd_clear);
      flags_q.thermal_shutdown_first_or_warning_second <=
        s.temp_shut_first |
        (flags_q.thermal_shutdown_first_or_warning_second &
         ~rd_clear);
      flags_q.thermal_shutdown_second <= s.temp_shut_second |
        (flags_q.thermal_shutdown_second & ~rd_clear);
      flags_q.pump_low_flag <= pump_low_cause |
        (flags_q.pump_low_flag & ~rd_clear);
      flags_q.shoot_through_flag <= st_cause |
        (flags_q.shoot_through_flag & {3{~rd_clear}});
      flags_q.upper_switch_short_flag <= hs_short_cause |
        (flags_q.upper_switch_short_flag & {3{~rd_clear}});
      flags_q.lower_switch_short_flag <= ls_short_cause |
        (flags_q.lower_switch_short_flag & {3{~rd_clear}});
    end
  end

  // Bit 0 functional, bit 1 device, bit 2 warning; off-state results
  // stay out on purpose.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      gsb_q <= '0;
    end else if (CE_I) begin
      gsb_q <= {5'h00,
        flags_q.thermal_warning_first |
          (ctrl_q.thermal_mode_select &
           flags_q.thermal_shutdown_first_or_warning_second),
        flags_q.disable_flag | therm_sd,
        flags_q.pump_low_flag | (|flags_q.shoot_through_flag) |
          (|flags_q.upper_switch_short_flag) |
          (|flags_q.lower_switch_short_flag)};
    end
  end

  assign GLOBAL_STATUS_O = gsb_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I || !CE_I);

  sequence s_both_active;
    !s.high_side_input_n[0] && s.low_side_input[0];
  endsequence
  sequence s_hi_released;
    $fell(gates.high_gate_out[0]);
  endsequence

  property p_pin_off;
    s.driver_off_pin |=> gates.high_gate_out == 3'h0 &&
                         gates.low_gate_out == 3'h0;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("gates on with pin high");

  property p_disable_hold;
    flags_q.disable_flag && !rd_clear |=> flags_q.disable_flag;
  endproperty
  a_disable_hold: assert property (p_disable_hold)
    else $error("flag lost");

  property p_cross;
    s_both_active |=> !gates.high_gate_out[0] && !gates.low_gate_out[0];
  endproperty
  a_cross: assert property (p_cross)
    else $error("both gates on");

  property p_dead;
    s_hi_released |-> !gates.low_gate_out[0] [*8];
  endproperty
  a_dead: assert property (p_dead)
    else $error("dead time short");

  property p_wake;
    wake_reg |=> mode_q == MODE_ACTIVE ##0 !INTERRUPT_OUT_N_O [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake pulse");

  property p_pump;
    (mode_q != MODE_ACTIVE || ctrl_q.pump_off_bit) |=> !PUMP_ENABLE_O;
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump not off");

  property p_warn_sd;
    ctrl_q.thermal_mode_select && s.temp_shut_second &&
    mode_q == MODE_ACTIVE |=> flags_q.thermal_shutdown_second ##1
      gates.high_gate_out == 3'h0 && !REGULATOR_ENABLE_O;
  endproperty
  a_warn_sd: assert property (p_warn_sd)
    else $error("no shutdown");

  property p_retry;
    mode_q == MODE_ACTIVE && s.temp_shut_second |=>
      retry_q == 3'($past(retry_q) + 3'h1) && !REGULATOR_ENABLE_O;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry not counted");

endmodule : gate_driver_protection_control
`default_nettype wire

/* verification/host_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the pins; floating pins settle to their pull levels.
module host_pins_model
  import gdp_pkg::*;
(
  input  wire logic     release_i, // Host pins floating.
  input  wire pins_type base_i,    // Host and sensor drive.
  output pins_type      pins_o     // Levels seen at the pins.
);
  // A released host must not leave the last level on the wires.
  always_comb begin
    pins_o = base_i;
    if (release_i) begin
      pins_o.driver_off_pin    = 1'b1;
      pins_o.high_side_input_n = 3'h7;
      pins_o.low_side_input    = 3'h0;
    end
  end
endmodule : host_pins_model
`default_nettype wire

/* verification/tb_gate_driver_protection_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gate_driver_protection_control
  import gdp_pkg::*;
;
  logic        CLK_I = 1'b0;
  logic        RESET_N_I = 1'b0;
  logic        rel = 1'b1;
  pins_type    base = '0;
  pins_type    pins;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdata;
  logic        stall;
  logic        pump;
  logic        reg_on;
  logic        int_n;
  logic [2:0]  sink;
  logic [1:0]  thr;
  logic [7:0]  global_status_byte;
  gates_type   gates;
  int          num_errors = 0;
  int          check_count = 0;
  typedef struct {logic [2:0] hn, l, hg, lg;} row_type;
  row_type rows [4] = '{'{3'h6,3'h0,3'h1,3'h0}, '{3'h7,3'h2,3'h0,3'h2},
    '{3'h5,3'h1,3'h2,3'h1}, '{3'h3,3'h4,3'h0,3'h0}};
  // The clock inverts every half period of 2.5 ns.
  always #2.5 CLK_I = ~CLK_I;
  host_pins_model host (.release_i(rel), .base_i(base), .pins_o(pins));
  gate_driver_protection_control #(.WAKE_CYC(20), .RETRY_CYC(10)) uut (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(1'b1), .PINS_I(pins),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(stall), .GATES_O(gates), .PUMP_ENABLE_O(pump),
    .REGULATOR_ENABLE_O(reg_on), .SINK_TEST_O(sink),
    .SHORT_THRESHOLD_O(thr), .INTERRUPT_OUT_N_O(int_n),
    .GLOBAL_STATUS_O(global_status_byte));
  task automatic chk(input string s, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One access, held until waitrequest is seen low at a rising edge;
  // only the watchdog ends a wait that never finishes.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge CLK_I);
    rd   <= ~w;
    wr   <= w;
    addr <= a;
    wd   <= d;
    do @(posedge CLK_I); while (stall !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdreg(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rdreg
  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // A hang is cut short well after the tests should end.
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    base.pump_ready <= 1'b1;
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h1);
    rel <= 1'b0;
    base.ignition_wake_input <= 1'b1;
    repeat (5) @(posedge CLK_I);
    rdreg(REG_FLAGS);
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h0);
    rdreg(REG_LIVE);
    chk("ign", {31'h0, q[0]}, 32'h1);
    foreach (rows[i]) begin
      base.high_side_input_n <= rows[i].hn;
      base.low_side_input <= rows[i].l;
      repeat (40) @(posedge CLK_I);
      chk("gates", {gates.high_gate_out, gates.low_gate_out},
          {rows[i].hg, rows[i].lg});
    end
    base.high_side_input_n <= 3'h6;
    base.low_side_input <= 3'h0;
    repeat (40) @(posedge CLK_I);
    chk("sink", {gates.fast_sink_high, gates.fast_sink_low}, 6'h37);
    base.driver_off_pin <= 1'b1;
    repeat (6) @(posedge CLK_I);
    chk("high", gates.high_gate_out, 3'h0);
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h81);
    base.temp_warn_first <= 1'b1;
    repeat (5) @(posedge CLK_I);
    rdreg(REG_FLAGS);
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h3);
    base.temp_warn_first <= 1'b0;
    base.driver_off_pin <= 1'b0;
    repeat (5) @(posedge CLK_I);
    rdreg(REG_FLAGS);
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h0);
    // Control fields reach their pins; the pump-off bit stops the pump.
    bus(1'b1, REG_CTRL, 32'h2a3);
    rdreg(REG_CTRL);
    chk("ctrl", q, 32'h2a3);
    chk("sinktest", sink, 3'h5);
    chk("threshold", thr, 2'h2);
    chk("pump", pump, 1'b0);
    // Warning mode: second shutdown stops regulator, pump and gates.
    bus(1'b1, REG_CTRL, 32'h1);
    base.temp_shut_second <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk("regulator", reg_on, 1'b0);
    base.temp_shut_second <= 1'b0;
    repeat (20) @(posedge CLK_I);
    chk("status", global_status_byte, 8'h02);
    chk("pump", pump, 1'b0);
    chk("high", gates.high_gate_out, 3'h0);
    rdreg(REG_LIVE);
    chk("retry", q[6:2], 5'h01);
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h8);
    repeat (3) @(posedge CLK_I);
    chk("pump", pump, 1'b1);
    // Regulator standby: ignition high wakes with a low interrupt pulse.
    base.ignition_wake_input <= 1'b0;
    repeat (4) @(posedge CLK_I);
    bus(1'b1, REG_CTRL, 32'h8001);
    rdreg(REG_LIVE);
    chk("mode", q[6:5], 2'h1);
    base.ignition_wake_input <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk("interrupt", int_n, 1'b0);
    repeat (26) @(posedge CLK_I);
    chk("interrupt", int_n, 1'b1);
    // A reset in mid-run drops the gates and sets the disable flag again.
    RESET_N_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    chk("gates", gates, 12'h03f);
    RESET_N_I <= 1'b1;
    rdreg(REG_FLAGS);
    chk("flags", q, 32'h1);
    results();
  end
endmodule : tb_gate_driver_protection_control
`default_nettype wire
